// ### design/adc_consts.svh
// offsets, field positions, reset values and timing counts of the converter control block
`ifndef ADC_CONSTS_SVH
`define ADC_CONSTS_SVH

`define ADC_ADDR_RESULT        8'h1E
`define ADC_ADDR_CONV_CONTROL  8'h1F
`define ADC_ADDR_PORT_CONFIG   8'h9F

`define ADC_CONV_CONTROL_RESET 8'h00
`define ADC_PORT_CONFIG_RESET  3'h0
`define ADC_CONV_CONTROL_MASK  8'hFD

`define ADC_CLKSEL_MSB         7
`define ADC_CLKSEL_LSB         6
`define ADC_CHSEL_MSB          5
`define ADC_CHSEL_LSB          3
`define ADC_GO_BIT             2
`define ADC_POWER_BIT          0

`define ADC_CLKSEL_OSC2        2'h0
`define ADC_CLKSEL_OSC8        2'h1
`define ADC_CLKSEL_OSC32       2'h2
`define ADC_CLKSEL_RC          2'h3

// oscillator periods per bit period for each oscillator selection (none for RC)
`define ADC_TAD_OSC2           2
`define ADC_TAD_OSC8           8
`define ADC_TAD_OSC32          32

// conversion length counted in half bit periods (9.5 bit periods)
`define ADC_CONV_HALF_PERIODS  5'h13
// first and last half period at which a result bit is decided
`define ADC_FIRST_DECIDE       5'h02
`define ADC_LAST_DECIDE        5'h10

`define ADC_TRIGGER_MODE       4'hB
`define ADC_SAR_START          8'h80

`endif

// ### design/adc_pkg.sv
// types of the converter control block
package adc_pkg;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_CONVERT
  } conv_state_type;

endpackage

// ### design/adc_conversion_control.sv
// conversion control, configuration registers and successive-approximation sequencer
//
// Behaviour
// - clock select sets bit period: 2/8/32 osc, RC
// - channel select routes one of five inputs
// - setting status bit starts conversion while powered
// - power bit enables converter, clear shuts off
// - config register upper five bits read zero
// - config field sets analog pins and reference
// - completion loads result, clears status, raises flag
// - result register untouched by reset
// - conversion lasts nine and a half bit periods
// - compare trigger mode 1011 starts when powered
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "adc_consts.svh"

module adc_conversion_control (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  // register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // conversion clock source and trigger
  input  wire logic       i_rc_half_tick,
  input  wire logic       i_special_trigger,
  input  wire logic [3:0] i_compare_mode_field,
  // analog core
  input  wire logic       i_compare,
  output logic            o_converter_power,
  output logic      [2:0] o_channel_select,
  output logic            o_hold,
  output logic      [7:0] o_trial,
  // pin roles: bit order ra0, ra1, ra2, ra5, ra3
  output logic      [4:0] o_pin_analog,
  output logic            o_vref_external,
  output logic            o_vref_ground,
  // completion event towards the interrupt flag
  output logic            o_conv_done_flag_set
);

  logic [7:0]                  conversion_control;
  logic [2:0]                  pin_config_field;
  logic [7:0]                  result_register;
  adc_pkg::conv_state_type     state;
  logic [4:0]                  div_count;
  logic [4:0]                  half_count;
  logic [7:0]                  sar;
  logic [7:0]                  sar_bit;
  logic                        half_tick;
  logic                        wr_control;
  logic                        wr_config;
  logic                        go_set_sw;
  logic                        go_clear_sw;
  logic                        trigger_start;
  logic                        start;
  logic                        abort;
  logic                        finish;
  logic                        decide;
  logic [4:0]                  half_limit;

  // pin role decode: analog mask, external reference, all digital
  function automatic logic [6:0] decode_pins(input logic [2:0] cfg);
    logic [6:0] r;
    r = 7'h00;
    if (cfg[2:1] == 2'h3) begin
      r = 7'h01;
    end else if (cfg[2]) begin
      // ra2 and ra5 go digital; ra3 stays analog unless it serves as the reference
      r = {cfg[0] ? 5'h18 : 5'h19, cfg[0], 1'b0};
    end else begin
      r = {cfg[0] ? 5'h1E : 5'h1F, cfg[0], 1'b0};
    end
    return r;
  endfunction

  // half bit period in oscillator cycles, less one
  function automatic logic [4:0] half_period(input logic [1:0] sel);
    logic [4:0] r;
    r = 5'h00;
    if (sel == `ADC_CLKSEL_OSC2) begin
      r = 5'((`ADC_TAD_OSC2 / 2) - 1);
    end else if (sel == `ADC_CLKSEL_OSC8) begin
      r = 5'((`ADC_TAD_OSC8 / 2) - 1);
    end else begin
      r = 5'((`ADC_TAD_OSC32 / 2) - 1);
    end
    return r;
  endfunction

  // next trial code: keep the tested bit when the input is at or above it, then try the next one down
  function automatic logic [7:0] next_trial(input logic [7:0] code,
                                            input logic [7:0] bit_under_test,
                                            input logic       keep);
    logic [7:0] r;
    r = keep ? code : (code & ~bit_under_test);
    return r | (bit_under_test >> 1);
  endfunction

  assign wr_control = i_wr && (i_addr == `ADC_ADDR_CONV_CONTROL);
  assign wr_config  = i_wr && (i_addr == `ADC_ADDR_PORT_CONFIG);

  // start only on a converter already powered
  assign go_set_sw   = wr_control && i_wdata[`ADC_GO_BIT] && i_wdata[`ADC_POWER_BIT]
                       && conversion_control[`ADC_POWER_BIT];
  // a write clearing status or power aborts, and drops a trigger of the same cycle
  assign go_clear_sw = wr_control && !(i_wdata[`ADC_GO_BIT] && i_wdata[`ADC_POWER_BIT]);
  // trigger needs mode 1011 and power
  assign trigger_start = i_special_trigger && (i_compare_mode_field == `ADC_TRIGGER_MODE)
                         && conversion_control[`ADC_POWER_BIT];

  assign start  = (state == adc_pkg::ST_IDLE) && (go_set_sw || (trigger_start && !go_clear_sw));
  assign abort  = (state == adc_pkg::ST_CONVERT)
                  && (go_clear_sw || (wr_control && !i_wdata[`ADC_POWER_BIT]));
  assign half_limit = half_period(conversion_control[`ADC_CLKSEL_MSB:`ADC_CLKSEL_LSB]);

  // half bit period tick from the selected source
  assign half_tick = (conversion_control[`ADC_CLKSEL_MSB:`ADC_CLKSEL_LSB] == `ADC_CLKSEL_RC)
                     ? i_rc_half_tick : (div_count == half_limit);

  assign finish = (state == adc_pkg::ST_CONVERT) && !abort && half_tick
                  && (half_count == `ADC_CONV_HALF_PERIODS - 5'h01);
  // eight decisions, one per bit period, as the half count reaches 2, 4 .. 16
  assign decide = (state == adc_pkg::ST_CONVERT) && half_tick
                  && (half_count >= `ADC_FIRST_DECIDE - 5'h01)
                  && (half_count <= `ADC_LAST_DECIDE - 5'h01) && half_count[0];

  // control register: software fields and status bit
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      conversion_control <= `ADC_CONV_CONTROL_RESET;
    end else begin
      if (wr_control) begin
        conversion_control <= i_wdata & `ADC_CONV_CONTROL_MASK;
        // status rises only with a real start, so a write in the completion cycle cannot leave it stuck
        conversion_control[`ADC_GO_BIT] <= start
                                           || (conversion_control[`ADC_GO_BIT] && i_wdata[`ADC_GO_BIT]
                                               && i_wdata[`ADC_POWER_BIT] && !finish);
      end else if (start) begin
        conversion_control[`ADC_GO_BIT] <= 1'b1;
      end else if (finish) begin
        conversion_control[`ADC_GO_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_config_field <= `ADC_PORT_CONFIG_RESET;
    end else if (wr_config) begin
      pin_config_field <= i_wdata[2:0];
    end
  end

  // sequencer state
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= adc_pkg::ST_IDLE;
    end else begin
      case (state)
        adc_pkg::ST_IDLE: begin
          if (start) begin
            state <= adc_pkg::ST_CONVERT;
          end
        end
        adc_pkg::ST_CONVERT: begin
          if (abort || finish) begin
            state <= adc_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= adc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // oscillator divider and half period counter, restarted at each start
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_count  <= 5'h00;
      half_count <= 5'h00;
    end else if (start || state == adc_pkg::ST_IDLE) begin
      div_count  <= 5'h00;
      half_count <= 5'h00;
    end else if (half_tick) begin
      div_count  <= 5'h00;
      half_count <= half_count + 5'h01;
    end else begin
      div_count  <= div_count + 5'h01;
    end
  end

  // successive approximation: keep a trial bit when the input is at or above it
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sar     <= 8'h00;
      sar_bit <= 8'h00;
    end else if (start) begin
      sar     <= `ADC_SAR_START;
      sar_bit <= `ADC_SAR_START;
    end else if (decide) begin
      sar     <= next_trial(sar, sar_bit, i_compare);
      sar_bit <= sar_bit >> 1;
    end
  end

  // no reset: content is unknown after power-on
  always_ff @(posedge i_clk) begin
    if (finish) begin
      result_register <= sar;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_conv_done_flag_set <= 1'b0;
    end else begin
      o_conv_done_flag_set <= finish;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_converter_power <= 1'b0;
    end else begin
      o_converter_power <= conversion_control[`ADC_POWER_BIT];
    end
  end

  // codes above four are not a channel; hold the last one
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_channel_select <= 3'h0;
    end else if (conversion_control[`ADC_CHSEL_MSB:`ADC_CHSEL_LSB] <= 3'h4) begin
      o_channel_select <= conversion_control[`ADC_CHSEL_MSB:`ADC_CHSEL_LSB];
    end
  end

  // sample held from the start edge until completion or abort
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_hold <= 1'b0;
    end else begin
      o_hold <= ((state == adc_pkg::ST_CONVERT) && !abort && !finish) || start;
    end
  end

  // trial code moves in step with the approximation register, so the comparator never sees a stale code
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_trial <= 8'h00;
    end else begin
      o_trial <= start ? `ADC_SAR_START : (decide ? next_trial(sar, sar_bit, i_compare) : sar);
    end
  end

  // pin roles and reference from the configuration field
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pin_analog    <= 5'h1F;
      o_vref_external <= 1'b0;
      o_vref_ground   <= 1'b0;
    end else begin
      {o_pin_analog, o_vref_external, o_vref_ground} <= decode_pins(pin_config_field);
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 8'h00;
    end else if (!i_rd) begin
      o_rdata <= 8'h00;
    end else if (i_addr == `ADC_ADDR_CONV_CONTROL) begin
      o_rdata <= conversion_control & `ADC_CONV_CONTROL_MASK;
    end else if (i_addr == `ADC_ADDR_PORT_CONFIG) begin
      o_rdata <= {5'h00, pin_config_field};
    end else if (i_addr == `ADC_ADDR_RESULT) begin
      o_rdata <= result_register;
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule

// ### sim/adc_conversion_control_properties.sv
// assertion checker for the converter control block
`timescale 1ns/1ps
module adc_conversion_control_checker (
  input wire logic       i_clk,
  input wire logic       i_reset_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_special_trigger,
  input wire logic [3:0] i_compare_mode_field,
  input wire logic       o_converter_power,
  input wire logic [2:0] o_channel_select,
  input wire logic       o_hold,
  input wire logic [7:0] o_trial,
  input wire logic [4:0] o_pin_analog,
  input wire logic       o_vref_external,
  input wire logic       o_vref_ground,
  input wire logic       o_conv_done_flag_set
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  logic [1:0] sel;
  logic [8:0] len;
  wire        ctl_wr = i_wr && i_addr == 8'h1F;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel <= 2'h0;
      len <= 9'h000;
    end else begin
      if (ctl_wr) sel <= i_wdata[7:6];
      len <= o_hold ? len + 9'h001 : 9'h000;
    end
  end
  // at the flag edge len still holds the hold length: nineteen half periods of 1, 4 or 16 clocks
  function automatic logic [8:0] conv_len(input logic [1:0] s);
    conv_len = (s == 2'h0) ? 9'h013 : (s == 2'h1) ? 9'h04C : 9'h130;
  endfunction
  sequence trig_go;
    i_special_trigger && i_compare_mode_field == 4'hB && o_converter_power && !o_hold && !i_wr;
  endsequence
  sequence sw_go;
    ctl_wr && i_wdata[2] && i_wdata[0] && o_converter_power && !o_hold && !$past(ctl_wr);
  endsequence
  sequence conv_begun;
    o_hold && o_trial == 8'h80;
  endsequence
  trig_start_a: assert property (trig_go |=> conv_begun) else $error("trigger start missed");
  trig_mode_a: assert property (
    i_special_trigger && i_compare_mode_field != 4'hB && !o_hold && !i_wr |=> !o_hold)
    else $error("trigger acted in wrong mode");
  sw_start_a: assert property (sw_go |=> conv_begun) else $error("software start missed");
  power_gate_a: assert property (
    ctl_wr && i_wdata[2] && !o_converter_power && !$past(ctl_wr) && !o_hold |=> !o_hold)
    else $error("start while unpowered");
  power_copy_a: assert property (ctl_wr |=> ##1 o_converter_power == $past(i_wdata[0], 2))
    else $error("power output wrong");
  conv_len_a: assert property (o_conv_done_flag_set && sel != 2'h3 |-> len == conv_len(sel))
    else $error("conversion length wrong");
  done_pulse_a: assert property (
    o_conv_done_flag_set |-> !o_hold && $past(o_hold, 2) ##1 !o_conv_done_flag_set)
    else $error("done pulse wrong");
  abort_quiet_a: assert property (
    ctl_wr && !i_wdata[2] && o_hold |=> (!o_hold && !o_conv_done_flag_set) [*4])
    else $error("abort did not stop");
  pin_roles_a: assert property (o_vref_ground == (o_pin_analog == 5'h00)
    && (!o_vref_external || (o_pin_analog[0] == 1'b0 && o_pin_analog[4:3] == 2'b11)))
    else $error("pin roles inconsistent");
  chan_range_a: assert property (o_channel_select <= 3'h4) else $error("channel out of range");
  cfg_upper_a: assert property ($past(i_rd) && $past(i_addr) == 8'h9F |-> o_rdata[7:3] == 5'h00)
    else $error("config upper bits set");
  ctl_bit1_a: assert property ($past(i_rd) && $past(i_addr) == 8'h1F |-> o_rdata[1] == 1'b0)
    else $error("control bit one set");
endmodule
bind adc_conversion_control adc_conversion_control_checker adc_conversion_control_checker_inst (.i_clk, .i_reset_n,
  .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_special_trigger, .i_compare_mode_field, .o_converter_power,
  .o_channel_select, .o_hold, .o_trial, .o_pin_analog, .o_vref_external, .o_vref_ground, .o_conv_done_flag_set);

// ### sim/analog_core_model.sv
// analog core stand-in: comparator against the level captured at hold
`timescale 1ns/1ps
module analog_core_model (
  input  wire logic       i_clk,
  input  wire logic       i_hold,
  input  wire logic [7:0] i_trial,
  input  wire logic [7:0] i_level,
  output logic            o_compare
);
  logic [7:0] held;
  logic       junk = 1'b0;
  // input tracks the pin until the hold closes
  always @(posedge i_clk) begin
    if (!i_hold) held <= i_level;
    junk <= ~junk;
  end
  // outside a conversion the comparator means nothing, so it wanders
  assign o_compare = i_hold ? (held >= i_trial) : junk;
endmodule

// ### sim/adc_conversion_control_tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module adc_conversion_control_tb_top;
  logic       i_clk = 1'b0, i_reset_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_rc_half_tick = 1'b0;
  logic       i_special_trigger = 1'b0, i_compare, o_converter_power, o_hold, o_vref_external, o_vref_ground;
  logic       o_conv_done_flag_set;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, o_trial, level = 8'h00, d;
  logic [3:0] i_compare_mode_field = 4'h0;
  logic [2:0] o_channel_select;
  logic [4:0] o_pin_analog;
  int         fail_count = 0, samples_checked = 0, flags = 0, exp_flags = 0;
  // reference model: every conversion the bench runs to completion queues the level it must return
  int         exp_q[$], model_result = 0;
  adc_conversion_control adc_conversion_control_inst (.i_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_rc_half_tick, .i_special_trigger, .i_compare_mode_field, .i_compare, .o_converter_power, .o_channel_select,
    .o_hold, .o_trial, .o_pin_analog, .o_vref_external, .o_vref_ground, .o_conv_done_flag_set);
  analog_core_model analog_core_model_inst (.i_clk, .i_hold(o_hold), .i_trial(o_trial), .i_level(level),
    .o_compare(i_compare));
  initial begin
    forever #4 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (o_conv_done_flag_set === 1'b1) flags++;
    i_rc_half_tick <= ($urandom % 3) == 0;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic trig(input logic [3:0] m);
    @(posedge i_clk);
    i_special_trigger <= 1'b1;
    i_compare_mode_field <= m;
    @(posedge i_clk);
    i_special_trigger <= 1'b0;
  endtask
  function automatic logic [7:0] pins(input int c);
    case (c)
      0, 2: pins = 8'h7C;
      1, 3: pins = 8'h7A;
      4: pins = 8'h64;
      5: pins = 8'h62;
      default: pins = 8'h01;
    endcase
  endfunction
  task automatic finish_conv();
    int k;
    k = 0;
    d = 8'h04;
    while (d[2] !== 1'b0 && k < 400) begin
      rd(8'h1F);
      k++;
    end
    repeat (3) @(posedge i_clk);
    exp_flags++;
    chk("flag_count", exp_flags, flags);
    rd(8'h1E);
    model_result = exp_q.pop_front();
    chk("result", model_result[7:0], d);
  endtask
  task automatic convert(input logic [1:0] s, input logic [2:0] ch);
    logic [7:0] c;
    c = {s, ch, 3'b001};
    wr(8'h1F, c);
    // acquisition settles before the start
    repeat (20) @(posedge i_clk);
    level = $urandom;
    exp_q.push_back(level);
    chk("channel", {5'h00, ch}, {5'h00, o_channel_select});
    wr(8'h1F, c | 8'h04);
    rd(8'h1F);
    chk("status_busy", c | 8'h04, d);
    finish_conv();
    repeat (64) @(posedge i_clk);
  endtask
  task automatic report_and_stop();
    if (fail_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    fail_count++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h2127));
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    // result register is not compared before the first conversion
    rd(8'h1F);
    chk("ctl_reset", 8'h00, d);
    rd(8'h9F);
    chk("cfg_reset", 8'h00, d);
    rd(8'h55);
    chk("unmapped", 8'h00, d);
    wr(8'h1F, 8'hFF);
    rd(8'h1F);
    chk("ctl_first_power", 8'hF9, d);
    for (int c = 0; c < 8; c++) begin
      wr(8'h9F, 8'hF8 | c[7:0]);
      rd(8'h9F);
      chk("cfg", c[7:0], d);
      chk("pins", pins(c), {1'b0, o_pin_analog, o_vref_external, o_vref_ground});
    end
    for (int s = 0; s < 5; s++) convert(s[1:0], s[2:0]);
    wr(8'h1F, 8'h55);
    repeat (10) @(posedge i_clk);
    wr(8'h1F, 8'h51);
    repeat (100) @(posedge i_clk);
    rd(8'h1F);
    chk("abort_status", 8'h51, d);
    chk("abort_flags", exp_flags, flags);
    rd(8'h1E);
    chk("abort_result", model_result[7:0], d);
    trig(4'h0);
    rd(8'h1F);
    chk("trig_wrong_mode", 8'h51, d);
    level = $urandom;
    exp_q.push_back(level);
    trig(4'hB);
    rd(8'h1F);
    chk("trig_start", 8'h55, d);
    finish_conv();
    wr(8'h1F, 8'h50);
    repeat (3) @(posedge i_clk);
    chk("power_off", 8'h00, {7'h00, o_converter_power});
    trig(4'hB);
    rd(8'h1F);
    chk("trig_unpowered", 8'h50, d);
    // a mid-run reset clears the control register but leaves the result alone
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rd(8'h1F);
    chk("ctl_rerun", 8'h00, d);
    rd(8'h1E);
    chk("result_kept", model_result[7:0], d);
    report_and_stop();
  end
endmodule
